// ---- jicu_arr_if.sv ----
// Request and answer bundle between the command unit and the array model.
// req and the array end run on the system clock; op, addr and wdata come from test-clock registers.
`timescale 1ns/1ns
`default_nettype none
interface jicu_arr_if #(
  parameter int unsigned ADDR_W = jicu_pkg::DEF_ADDR_W,
  parameter int unsigned ROW_W  = jicu_pkg::DEF_ROW_W
);
  logic                 req;    // One-cycle start pulse
  jicu_pkg::jicu_op_t   op;
  logic [ADDR_W-1:0]    addr;
  logic [ROW_W-1:0]     wdata;
  logic                 done;   // One-cycle end pulse
  logic [ROW_W-1:0]     rdata;
  logic                 busy;

  modport ctl (output req, output op, output addr, output wdata,
               input done, input rdata, input busy);
  modport mem (input req, input op, input addr, input wdata,
               output done, output rdata, output busy);
endinterface
`default_nettype wire

// ---- jicu_cmd_unit.sv ----
// Test-port programming command unit: controller, instruction decode, shift paths,
// and the hand-off of array operations to the system clock domain.
// Assumes tck_i is the host's test clock and may stop between scans.
// Overview of operation
// - Enable instruction 01001 unlocks erase, program and verify; these are ignored before.
// - Preloaded boundary values drive the pins while programming mode is on.
// - Erase instruction 01010 clears the whole array through the programming register path.
// - Program instruction 01011 writes the shift register into the addressed row.
// - Disable instruction 10000 leaves programming mode, register stays between data pins.
// - Verify instruction 01100 copies the addressed row into the shift register.
// - During erase the user pins hold the preloaded boundary values.
// - Data in sampled on rising clock, out on falling, tristated when idle.
// - Port enable high reclaims test pins used as user I/O; low returns them.
`timescale 1ns/1ns
`default_nettype none
module jicu_cmd_unit #(
  parameter int unsigned ADDR_W       = jicu_pkg::DEF_ADDR_W,
  parameter int unsigned ROW_W        = jicu_pkg::DEF_ROW_W,
  parameter int unsigned N_IO         = jicu_pkg::DEF_N_IO,
  parameter int unsigned ERASE_CYCLES = jicu_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYCLES  = jicu_pkg::PROG_CYC
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             tck_i,
  input  wire logic             tms_i,
  input  wire logic             tdi_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  input  wire logic             port_en_i,
  input  wire logic             pins_user_i,
  input  wire logic [N_IO-1:0]  user_out_i,
  output logic      [N_IO-1:0]  pin_o,
  output logic                  isp_mode_o,
  output logic                  busy_o
);
  import jicu_pkg::*;
  localparam int unsigned SR_W = ADDR_W + ROW_W;

  if (ADDR_W < 1 || ROW_W < 1 || N_IO < 1 || ADDR_W > 12) begin : g_bad_geom
    $error("unsupported array or pin geometry");
  end

  // Test-clock domain state
  typedef struct packed {
    jicu_tap_t          tap;
    logic [IR_W-1:0]    ir;
    logic [IR_W-1:0]    ir_sh;
    logic               isp_en;
    logic [N_IO-1:0]    bsr_sh;
    logic [N_IO-1:0]    bsr_upd;
    logic [SR_W-1:0]    isp_sh;
    logic               bypass;
    logic               req_tgl;
    jicu_op_t           op;
    logic [ADDR_W-1:0]  addr;
    logic [ROW_W-1:0]   wdata;
    logic               ack_s1;
    logic               ack_s2;
    logic               ack_seen;
    logic               rst_s1;
    logic               rst_s2;
    logic               pen_s1;
    logic               pen_s2;
    logic               cfg_s1;
    logic               cfg_s2;
  } jicu_tck_state_t;

  // System-clock domain state
  typedef struct packed {
    logic               req_s1;
    logic               req_s2;
    logic               req_seen;
    logic               en_s1;
    logic               en_s2;
    logic               en_prev;
    logic [N_IO-1:0]    hold;
    logic [N_IO-1:0]    pins;
    logic               ack_tgl;
    logic [ROW_W-1:0]   rdata_hold;
    logic               req;
    logic               busy;
  } jicu_sys_state_t;

  jicu_tck_state_t t;
  jicu_tck_state_t next_t;
  jicu_sys_state_t c;
  jicu_sys_state_t next_c;
  logic            live;
  logic            shifting;
  logic            tdo_bit;

  jicu_arr_if #(.ADDR_W(ADDR_W), .ROW_W(ROW_W)) arr ();

  // Test-clock side: controller, scan paths and operation requests
  always_comb begin
    next_t = t;
    next_t.rst_s1 = sys_rst_i;
    next_t.rst_s2 = t.rst_s1;
    next_t.ack_s1 = c.ack_tgl;
    next_t.ack_s2 = t.ack_s1;
    next_t.pen_s1 = port_en_i;
    next_t.pen_s2 = t.pen_s1;
    next_t.cfg_s1 = pins_user_i;
    next_t.cfg_s2 = t.cfg_s1;
    // Pins given to user logic keep the controller parked until reclaimed
    live = !t.cfg_s2 || t.pen_s2;
    next_t.tap = live ? jicu_tap_next(t.tap, tms_i) : T_RESET;
    unique case (t.tap)
      T_RESET: begin
        next_t.ir     = IR_BYPASS;
        next_t.isp_en = 1'b0;
      end
      T_CAP_IR: next_t.ir_sh = IR_CAPTURE;
      T_SH_IR:  next_t.ir_sh = {tdi_i, t.ir_sh[IR_W-1:1]};  // Rising-edge sample
      T_UPD_IR: begin
        next_t.ir = t.ir_sh;
        if (t.ir_sh == IR_ENABLE) next_t.isp_en = 1'b1;
        if (t.ir_sh == IR_DISABLE) next_t.isp_en = 1'b0;
        // Locked operations are dropped silently
        if (jicu_is_op(t.ir_sh) && t.isp_en) begin
          next_t.req_tgl = ~t.req_tgl;
          next_t.op      = (t.ir_sh == IR_ERASE)   ? OP_ERASE :
                           (t.ir_sh == IR_PROGRAM) ? OP_PROGRAM : OP_VERIFY;
          next_t.addr    = t.isp_sh[SR_W-1 -: ADDR_W];
          next_t.wdata   = t.isp_sh[ROW_W-1:0];
        end
      end
      T_CAP_DR: begin
        next_t.bypass = 1'b0;
        if (t.ir == IR_PRELOAD) next_t.bsr_sh = t.bsr_upd;
      end
      T_SH_DR: begin
        if (t.ir == IR_PRELOAD) next_t.bsr_sh = {tdi_i, t.bsr_sh[N_IO-1:1]};
        else if (jicu_is_isp(t.ir)) next_t.isp_sh = {tdi_i, t.isp_sh[SR_W-1:1]};
        else next_t.bypass = tdi_i;
      end
      T_UPD_DR: if (t.ir == IR_PRELOAD) next_t.bsr_upd = t.bsr_sh;
      T_IDLE, T_SEL_DR, T_EX1_DR, T_PAU_DR, T_EX2_DR,
      T_SEL_IR, T_EX1_IR, T_PAU_IR, T_EX2_IR: ;
    endcase
    // Returned row lands in the data part, ready to shift out
    if (t.ack_s2 != t.ack_seen) begin
      next_t.ack_seen = t.ack_s2;
      if (t.op == OP_VERIFY) next_t.isp_sh[ROW_W-1:0] = c.rdata_hold;
    end
    if (t.rst_s2) begin
      next_t.tap      = T_RESET;
      next_t.ir       = IR_BYPASS;
      next_t.ir_sh    = '0;
      next_t.isp_en   = 1'b0;
      next_t.bsr_sh   = '0;
      next_t.bsr_upd  = '0;
      next_t.isp_sh   = '0;
      next_t.bypass   = 1'b0;
      next_t.req_tgl  = 1'b0;
      next_t.op       = OP_ERASE;
      next_t.addr     = '0;
      next_t.wdata    = '0;
      next_t.ack_seen = t.ack_s2;
    end
  end

  always_ff @(posedge tck_i) begin
    t <= next_t;
  end

  // Output bit selection for the falling-edge driver
  assign shifting = (t.tap == T_SH_IR) || (t.tap == T_SH_DR);
  assign tdo_bit  = (t.tap == T_SH_IR) ? t.ir_sh[0] :
                    (t.ir == IR_PRELOAD) ? t.bsr_sh[0] :
                    jicu_is_isp(t.ir) ? t.isp_sh[0] : t.bypass;

  // Falling edge gives the host half a test clock of hold on the data out
  always_ff @(negedge tck_i) begin
    if (t.rst_s2) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o    <= tdo_bit;
      tdo_oe_o <= shifting;
    end
  end

  // System side: request toggle, preload hand-over and answer toggle
  always_comb begin
    next_c = c;
    next_c.req_s1  = t.req_tgl;
    next_c.req_s2  = c.req_s1;
    next_c.en_s1   = t.isp_en;
    next_c.en_s2   = c.en_s1;
    next_c.en_prev = c.en_s2;
    next_c.req     = 1'b0;
    if (c.req_s2 != c.req_seen) begin
      next_c.req_seen = c.req_s2;
      next_c.req      = 1'b1;
    end
    // Preload is stable before enable, so it is caught once on the rise
    if (c.en_s2 && !c.en_prev) next_c.hold = t.bsr_upd;
    next_c.pins = c.en_prev ? c.hold : user_out_i;
    if (arr.done) begin
      next_c.rdata_hold = arr.rdata;
      next_c.ack_tgl    = ~c.ack_tgl;
    end
    next_c.busy = arr.busy;
    if (sys_rst_i) begin
      next_c.req_seen   = c.req_s2;
      next_c.en_prev    = 1'b0;
      next_c.hold       = '0;
      next_c.pins       = '0;
      next_c.ack_tgl    = 1'b0;
      next_c.rdata_hold = '0;
      next_c.req        = 1'b0;
      next_c.busy       = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    c <= next_c;
  end

  // Payload words stay frozen in the test domain until the next request
  assign arr.req   = c.req;
  assign arr.op    = t.op;
  assign arr.addr  = t.addr;
  assign arr.wdata = t.wdata;

  jicu_nv_array #(
    .ADDR_W       (ADDR_W),
    .ROW_W        (ROW_W),
    .ERASE_CYCLES (ERASE_CYCLES),
    .PROG_CYCLES  (PROG_CYCLES)
  ) u_array (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .arr       (arr.mem)
  );

  assign pin_o      = c.pins;
  assign isp_mode_o = c.en_prev;
  assign busy_o     = c.busy;

  sequence s_upd_op;
    t.tap == T_UPD_IR && jicu_is_op(t.ir_sh);
  endsequence

  chk_locked_ops_drop: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    s_upd_op ##0 !t.isp_en |=> t.req_tgl == $past(t.req_tgl))
    else $error("operation issued while locked");
  chk_enable_unlock: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    (t.tap == T_UPD_IR && t.ir_sh == IR_ENABLE) |=> t.isp_en)
    else $error("enable did not unlock");
  chk_erase_request: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    s_upd_op ##0 (t.isp_en && t.ir_sh == IR_ERASE) |=>
      t.op == OP_ERASE && t.req_tgl != $past(t.req_tgl))
    else $error("erase not requested");
  chk_program_request: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    s_upd_op ##0 (t.isp_en && t.ir_sh == IR_PROGRAM) |=>
      t.op == OP_PROGRAM && t.wdata == $past(t.isp_sh[ROW_W-1:0]))
    else $error("program payload wrong");
  chk_isp_path_shift: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    (t.tap == T_SH_DR && t.ir == IR_DISABLE) |=> t.isp_sh[SR_W-1] == $past(tdi_i))
    else $error("programming register not on the data path");
  chk_tdo_idle_off: assert property (@(negedge tck_i) disable iff (t.rst_s2)
    !shifting |=> !tdo_oe_o)
    else $error("data out driven outside a shift");
  chk_port_gate: assert property (@(posedge tck_i) disable iff (t.rst_s2)
    (t.cfg_s2 && !t.pen_s2) |=> t.tap == T_RESET)
    else $error("controller ran while pins belonged to user logic");
  chk_preload_pins: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (c.en_prev && c.en_s2) |=> pin_o == $past(c.hold))
    else $error("pins not held at preload values");
  chk_verify_return: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    arr.done |=> c.rdata_hold == $past(arr.rdata) && c.ack_tgl != $past(c.ack_tgl))
    else $error("verify answer not handed back");
endmodule
`default_nettype wire

// ---- jicu_host_model.sv ----
// Test-port host model: drives the serial clock, mode and data pins and reads data out.
// Assumes the unit samples on rising and launches data out on falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module jicu_host_model #(
  parameter int unsigned SR_W = 20,
  parameter int unsigned N_IO = 8
) (
  output logic     tck_o,
  output logic     tms_o,
  output logic     tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic tdo_line;

  // A released data-out line floats up to the weak pull-up
  assign tdo_line = tdo_oe_i ? tdo_i : 1'b1;

  // Clock stands low outside frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One period: pins move just after the falling edge, data out is taken at the rising edge
  // Edges sit 3 ns off the period boundary so they never meet a system clock edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    #3;
    tms_o = tms;
    tdi_o = tdi;
    #34;
    tck_o = 1'b1;
    tdo = tdo_line;
    #40;
    tck_o = 1'b0;
    #3;
  endtask

  // Idle clocking long enough to cover an array pulse before the next scan
  task automatic idle(input int n);
    logic b;
    repeat (n) step(1'b0, 1'b0, b);
  endtask

  // Mode held high reaches the reset state from any state, then settle in idle
  task automatic goto_idle();
    logic b;
    repeat (6) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask

  // Full scan from idle back to idle; bit 0 goes first both ways
  task automatic shift(input int n, input logic [31:0] din, input bit ir,
                       output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) begin
      step(1'b1, 1'b0, b);
    end
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask

  task automatic ir_scan(input logic [4:0] code, output logic [4:0] cap);
    logic [31:0] d;
    shift(5, {27'h0, code}, 1'b1, d);
    cap = d[4:0];
  endtask

  task automatic dr_isp(input logic [SR_W-1:0] din, output logic [SR_W-1:0] dout);
    logic [31:0] d;
    shift(SR_W, 32'(din), 1'b0, d);
    dout = d[SR_W-1:0];
  endtask

  task automatic dr_bsr(input logic [N_IO-1:0] din, output logic [N_IO-1:0] dout);
    logic [31:0] d;
    shift(N_IO, 32'(din), 1'b0, d);
    dout = d[N_IO-1:0];
  endtask
endmodule
`default_nettype wire

// ---- jicu_nv_array.sv ----
// Nonvolatile configuration array with timed erase, program and read pulses.
// Assumes op, addr and wdata are stable in the cycle that req is high.
`timescale 1ns/1ns
`default_nettype none
module jicu_nv_array #(
  parameter int unsigned ADDR_W     = jicu_pkg::DEF_ADDR_W,
  parameter int unsigned ROW_W      = jicu_pkg::DEF_ROW_W,
  parameter int unsigned ERASE_CYCLES = jicu_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYCLES  = jicu_pkg::PROG_CYC
) (
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  jicu_arr_if.mem     arr
);
  import jicu_pkg::*;
  localparam int unsigned ROWS = 1 << ADDR_W;

  typedef struct packed {
    jicu_arr_st_t                st;
    logic [31:0]                 cnt;
    jicu_op_t                    op;
    logic [ADDR_W-1:0]           addr;
    logic [ROW_W-1:0]            wdata;
    logic [ROWS-1:0][ROW_W-1:0]  mem;
    logic                        done;
    logic [ROW_W-1:0]            rdata;
  } jicu_arr_state_t;

  jicu_arr_state_t s;
  jicu_arr_state_t next_s;

  if (ERASE_CYCLES < 1 || PROG_CYCLES < 1) begin : g_bad_len
    $error("pulse lengths must be at least one cycle");
  end

  // Pulse sequencer; the array is deliberately left out of the reset, it is nonvolatile
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.st)
      A_IDLE: if (arr.req) begin
        next_s.st    = A_PULSE;
        next_s.op    = arr.op;
        next_s.addr  = arr.addr;
        next_s.wdata = arr.wdata;
        next_s.cnt   = (arr.op == OP_ERASE)   ? 32'(ERASE_CYCLES - 1) :
                       (arr.op == OP_PROGRAM) ? 32'(PROG_CYCLES - 1)  : 32'(VERIFY_CYC - 1);
      end
      A_PULSE: if (s.cnt == '0) begin
        next_s.st   = A_IDLE;
        next_s.done = 1'b1;
        unique case (s.op)
          OP_ERASE:   next_s.mem = '0;                 // Whole array only
          OP_PROGRAM: next_s.mem[s.addr] = s.wdata;
          OP_VERIFY:  next_s.rdata = s.mem[s.addr];
          default:    next_s.rdata = '0;
        endcase
      end else begin
        next_s.cnt = s.cnt - 32'h1;
      end
    endcase
    if (sys_rst_i) begin
      next_s.st    = A_IDLE;
      next_s.cnt   = '0;
      next_s.op    = OP_ERASE;
      next_s.addr  = '0;
      next_s.wdata = '0;
      next_s.done  = 1'b0;
      next_s.rdata = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  assign arr.done  = s.done;
  assign arr.rdata = s.rdata;
  assign arr.busy  = (s.st != A_IDLE);

  sequence s_last_pulse(jicu_op_t o);
    s.st == A_PULSE && s.cnt == '0 && s.op == o;
  endsequence

  chk_erase_all_rows: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_last_pulse(OP_ERASE) |=> (s.mem == '0) && s.done && s.st == A_IDLE)
    else $error("erase left a cell set");
  chk_program_row_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_last_pulse(OP_PROGRAM) |=> s.mem[$past(s.addr)] == $past(s.wdata))
    else $error("program did not write the addressed row");
  chk_verify_row_copy: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_last_pulse(OP_VERIFY) |=> s.rdata == $past(s.mem[s.addr]) && s.done)
    else $error("verify did not return the addressed row");
endmodule
`default_nettype wire

// ---- jicu_pkg.sv ----
// Shared constants, types and helpers for the test-port programming command unit.
// Assumes a 100 MHz system clock and a test clock no faster than 12.5 MHz.
package jicu_pkg;

  // Instruction register
  localparam int unsigned IR_W = 5;
  localparam logic [IR_W-1:0] IR_PRELOAD = 5'h02;
  localparam logic [IR_W-1:0] IR_ENABLE  = 5'h09;
  localparam logic [IR_W-1:0] IR_ERASE   = 5'h0A;
  localparam logic [IR_W-1:0] IR_PROGRAM = 5'h0B;
  localparam logic [IR_W-1:0] IR_VERIFY  = 5'h0C;
  localparam logic [IR_W-1:0] IR_DISABLE = 5'h10;
  localparam logic [IR_W-1:0] IR_BYPASS  = 5'h1F;
  localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;  // Fixed pattern seen on an IR scan

  // Default geometry
  localparam int unsigned DEF_ADDR_W = 4;
  localparam int unsigned DEF_ROW_W  = 16;
  localparam int unsigned DEF_N_IO   = 8;

  // Pulse times, as printed, and their cycle counts (minimum times round up)
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ERASE_PULSE_MS  = 100;
  localparam int unsigned PROG_PULSE_MS   = 10;
  localparam int unsigned VERIFY_PULSE_US = 10;
  localparam int unsigned ERASE_CYC  = (ERASE_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC   = (PROG_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned VERIFY_CYC = (VERIFY_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {OP_ERASE, OP_PROGRAM, OP_VERIFY} jicu_op_t;
  typedef enum logic {A_IDLE, A_PULSE} jicu_arr_st_t;
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PAU_DR, T_EX2_DR, T_UPD_DR,
    T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PAU_IR, T_EX2_IR, T_UPD_IR
  } jicu_tap_t;

  // Test-port controller walk
  function automatic jicu_tap_t jicu_tap_next(input jicu_tap_t s, input logic tms);
    jicu_tap_t n;
    n = s;
    unique case (s)
      T_RESET:  n = tms ? T_RESET  : T_IDLE;
      T_IDLE:   n = tms ? T_SEL_DR : T_IDLE;
      T_SEL_DR: n = tms ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: n = tms ? T_EX1_DR : T_SH_DR;
      T_SH_DR:  n = tms ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: n = tms ? T_UPD_DR : T_PAU_DR;
      T_PAU_DR: n = tms ? T_EX2_DR : T_PAU_DR;
      T_EX2_DR: n = tms ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: n = tms ? T_SEL_DR : T_IDLE;
      T_SEL_IR: n = tms ? T_RESET  : T_CAP_IR;
      T_CAP_IR: n = tms ? T_EX1_IR : T_SH_IR;
      T_SH_IR:  n = tms ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: n = tms ? T_UPD_IR : T_PAU_IR;
      T_PAU_IR: n = tms ? T_EX2_IR : T_PAU_IR;
      T_EX2_IR: n = tms ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: n = tms ? T_SEL_DR : T_IDLE;
    endcase
    return n;
  endfunction

  // Instructions that route the programming shift register
  function automatic logic jicu_is_isp(input logic [IR_W-1:0] ir);
    return ir inside {IR_ENABLE, IR_ERASE, IR_PROGRAM, IR_DISABLE, IR_VERIFY};
  endfunction

  // Instructions that start an array operation
  function automatic logic jicu_is_op(input logic [IR_W-1:0] ir);
    return ir inside {IR_ERASE, IR_PROGRAM, IR_VERIFY};
  endfunction

endpackage

// ---- testbench.sv ----
// Self-checking bench for the test-port programming command unit.
// Assumes the host model makes the 80 ns test clock; erase and program pulses are shortened by parameter.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import jicu_pkg::*;
  localparam int unsigned SR_W = DEF_ADDR_W + DEF_ROW_W;
  logic                 clock_i;
  logic                 sys_rst_i;
  logic                 port_en;
  logic                 pins_user;
  logic [DEF_N_IO-1:0]  user_out;
  logic [DEF_N_IO-1:0]  hold;
  logic [DEF_N_IO-1:0]  pin;
  logic                 tck, tms, tdi, tdo, tdo_oe, isp_mode, busy;
  int                   err_count, num_checks, busy_cnt, cycles;

  always #5 clock_i = ~clock_i;

  jicu_cmd_unit #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) u_jicu_cmd_unit (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .port_en_i(port_en), .pins_user_i(pins_user),
    .user_out_i(user_out), .pin_o(pin), .isp_mode_o(isp_mode), .busy_o(busy));

  jicu_host_model host (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pins must show the preload while a pulse runs; the cycle ceiling cuts a hang short
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
      chk(32'(pin), 32'(hold), "pins during pulse");
    end
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end

  // Verify a row: address scan, verify, wait out the read pulse, shift the result out
  task automatic read_row(input logic [DEF_ADDR_W-1:0] r, output logic [SR_W-1:0] o);
    logic [4:0] c;
    host.dr_isp({r, 16'h5A5A}, o);
    host.ir_scan(IR_VERIFY, c);
    host.idle(140);
    host.dr_isp({r, 16'h0F0F}, o);
  endtask

  task automatic t_refused();
    logic [4:0] c;
    int b0;
    b0 = busy_cnt;
    host.ir_scan(IR_ERASE, c);
    chk(32'(c), 32'h1, "capture pattern");
    host.idle(12);
    chk(32'(busy_cnt - b0), 32'h0, "erase before enable");
    chk(32'(isp_mode), 32'h0, "mode before enable");
    chk(32'(tdo_oe), 32'h0, "data out released in idle");
    $display("test refused done");
  endtask

  task automatic t_port_en();
    logic [DEF_N_IO-1:0] bo;
    logic [4:0] c;
    @(posedge clock_i) pins_user <= 1'b1;
    host.goto_idle();
    host.ir_scan(IR_BYPASS, c);
    chk(32'(c), 32'h1F, "port held while given to user");
    @(posedge clock_i) port_en <= 1'b1;
    host.goto_idle();
    host.ir_scan(IR_BYPASS, c);
    chk(32'(c), 32'h1, "port reclaimed");
    host.dr_bsr(8'hA5, bo);
    chk(32'(bo), 32'h4A, "bypass passes one bit late");
    @(posedge clock_i) port_en <= 1'b0;
    pins_user <= 1'b0;
    host.goto_idle();
    $display("test port enable done");
  endtask

  task automatic t_enable();
    logic [DEF_N_IO-1:0] bo;
    logic [4:0] c;
    host.ir_scan(IR_PRELOAD, c);
    host.dr_bsr(8'hA5, bo);
    chk(32'(pin), 32'(user_out), "preload leaves pins alone");
    hold = 8'hA5;
    host.ir_scan(IR_ENABLE, c);
    host.idle(4);
    chk(32'(isp_mode), 32'h1, "enable");
    chk(32'(pin), 32'hA5, "pins from preload");
    $display("test enable done");
  endtask

  task automatic t_erase();
    logic [SR_W-1:0] o;
    logic [4:0] c;
    int b0;
    b0 = busy_cnt;
    host.ir_scan(IR_ERASE, c);
    host.idle(12);
    chk(32'(busy_cnt - b0 >= 19), 32'h1, "erase pulse ran");
    read_row(4'h0, o);
    chk(32'(o), 32'h00000, "row 0 erased");
    read_row(4'hF, o);
    chk(32'(o), 32'hF0000, "row 15 erased");
    $display("test erase done");
  endtask

  task automatic t_program();
    logic [SR_W-1:0] o;
    logic [4:0] c;
    int b0;
    b0 = busy_cnt;
    host.dr_isp({4'h0, 16'hBEEF}, o);
    host.ir_scan(IR_PROGRAM, c);
    host.idle(12);
    host.dr_isp({4'hF, 16'h1234}, o);
    host.ir_scan(IR_PROGRAM, c);
    host.idle(12);
    chk(32'(busy_cnt - b0 >= 18), 32'h1, "program pulses ran");
    read_row(4'h0, o);
    chk(32'(o), 32'h0BEEF, "row 0 read back");
    read_row(4'hF, o);
    chk(32'(o), 32'hF1234, "row 15 read back");
    read_row(4'h7, o);
    chk(32'(o), 32'h70000, "untouched row");
    $display("test program done");
  endtask

  task automatic t_disable();
    logic [SR_W-1:0] o;
    logic [4:0] c;
    @(posedge clock_i) user_out <= 8'hC3;
    host.ir_scan(IR_DISABLE, c);
    host.dr_isp(20'hABCDE, o);
    host.dr_isp(20'h13579, o);
    chk(32'(o), 32'hABCDE, "register between data pins");
    host.idle(4);
    chk(32'(isp_mode), 32'h0, "mode left");
    chk(32'(pin), 32'hC3, "pins back to user logic");
    $display("test disable done");
  endtask

  // Reset stays high until the test clock has also run through several edges
  initial begin
    clock_i   = 1'b0;
    sys_rst_i = 1'b1;
    port_en   = 1'b0;
    pins_user = 1'b0;
    user_out  = 8'h3C;
    hold      = 8'h00;
    host.goto_idle();
    @(posedge clock_i) sys_rst_i <= 1'b0;
    host.goto_idle();
    t_refused();
    t_port_en();
    t_enable();
    t_erase();
    t_program();
    t_disable();
    close_out();
  end
endmodule
`default_nettype wire
